/* File: verilog/pst_pkg.sv */
// Package for the status and telemetry register bank.
// Assumes a command-code register access port driven by the bus front end.
package pst_pkg;
    // Command codes
    localparam logic [7:0] PST_CMD_TEMP_STATUS = 8'h7d;
    localparam logic [7:0] PST_CMD_CML_STATUS = 8'h7e;
    localparam logic [7:0] PST_CMD_MON_STATUS = 8'h80;
    localparam logic [7:0] PST_CMD_VIN_READING = 8'h88;
    localparam logic [7:0] PST_CMD_IIN_READING = 8'h89;
    localparam logic [7:0] PST_CMD_VOUT_READING = 8'h8b;
    // Reset values
    localparam logic [7:0] PST_STATUS_RESET = 8'h00;
    localparam logic [15:0] PST_READING_RESET = 16'h0000;
    // Temperature status fields
    localparam int PST_TEMP_OVER_FAULT_BIT = 7;
    localparam int PST_TEMP_OVER_WARN_BIT = 6;
    localparam int PST_TEMP_UNDER_WARN_BIT = 5;
    localparam int PST_TEMP_UNDER_FAULT_BIT = 4;
    localparam logic [7:0] PST_TEMP_USED_MASK = 8'hf0;
    // Communication status fields
    localparam int PST_CML_BAD_CMD_BIT = 7;
    localparam int PST_CML_BAD_DATA_BIT = 6;
    localparam int PST_CML_PEC_BIT = 5;
    localparam int PST_CML_OTHER_BIT = 1;
    localparam logic [7:0] PST_CML_USED_MASK = 8'he2;
    // Monitor and sync status fields
    localparam int PST_MON_SHARE_BIT = 6;
    localparam int PST_MON_UV_WARN_BIT = 5;
    localparam int PST_MON_OV_WARN_BIT = 4;
    localparam int PST_MON_SYNC_BIT = 3;
    localparam int PST_MON_UV_FAULT_BIT = 1;
    localparam int PST_MON_OV_FAULT_BIT = 0;
    localparam logic [7:0] PST_MON_USED_MASK = 8'h7b;
    // Overall status word summary bits
    localparam int PST_WORD_CML_BIT = 1;
    localparam int PST_WORD_TEMP_BIT = 2;
    localparam int PST_WORD_OTHER_BIT = 9;
    // Warning margin: one tenth of the limit
    localparam int PST_WARN_DIVISOR = 10;
endpackage : pst_pkg

/* File: verilog/pst_sticky_byte.sv */
// Sticky status byte: flags latch until a clear-faults pulse or reset.
// Assumes event inputs are synchronous to clk_i.
`timescale 1ns/1ps
module pst_sticky_byte #(
    parameter logic [7:0] USED_MASK = 8'hff
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic clear_i,
    input wire logic [7:0] set_i,
    output logic [7:0] flags_o
);
    import pst_pkg::*;
    logic [7:0] flags_reg; // Latched flags
    logic [7:0] flags_next; // Next flags

    // Set beats clear so an event in the clear cycle is kept
    always_comb begin
        flags_next = clear_i ? PST_STATUS_RESET : flags_reg;
        flags_next = (flags_next | set_i) & USED_MASK; // RL21
    end

    // Register only
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flags_reg <= PST_STATUS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags_o = flags_reg;
endmodule : pst_sticky_byte

/* File: verilog/pst_monitor_compare.sv */
// Monitor-pin window comparator against the programmed fault limits.
// Assumes pin reading and limits share one unsigned scale.
`timescale 1ns/1ps
module pst_monitor_compare #(
    parameter int WIDTH = 16
) (
    input wire logic [WIDTH-1:0] level_i,
    input wire logic [WIDTH-1:0] uv_limit_i,
    input wire logic [WIDTH-1:0] ov_limit_i,
    output logic uv_fault_o,
    output logic ov_fault_o,
    output logic uv_warn_o,
    output logic ov_warn_o
);
    import pst_pkg::*;
    logic [WIDTH+3:0] uv_band; // Limit minus ten percent
    logic [WIDTH+3:0] ov_band; // Limit plus ten percent

    // Ten percent band, widened so the sum cannot wrap
    always_comb begin
        uv_band = {4'h0, uv_limit_i} - ({4'h0, uv_limit_i} / (WIDTH+4)'(PST_WARN_DIVISOR));
        ov_band = {4'h0, ov_limit_i} + ({4'h0, ov_limit_i} / (WIDTH+4)'(PST_WARN_DIVISOR));
        uv_fault_o = level_i < uv_limit_i; // RL13
        ov_fault_o = level_i > ov_limit_i; // RL14
        uv_warn_o = {4'h0, level_i} < uv_band; // RL10
        ov_warn_o = {4'h0, level_i} > ov_band; // RL11
    end
endmodule : pst_monitor_compare

/* File: verilog/pst_status_telemetry_regs.sv */
// Status and telemetry register bank read by command code.
// Assumes a bus front end presents decoded commands and error pulses.
// Telemetry words arrive ready coded; this bank only samples them.
// Clearing is one pulse for all three status bytes, pages included.
//
// Contract
// RL1: 7Dh returns paged temperature byte, reset zero
// RL2: Temperature bits 7..4 OT/UT flags, rest zero
// RL3: 7Eh returns global comm byte, reset zero
// RL4: Bit 7 set on unsupported command code
// RL5: Bit 6 set on unsupported command data
// RL6: Bit 5 set on packet error
// RL7: Bit 1 on read-only write or other
// RL8: 80h returns global monitor byte, reset zero
// RL9: Bit 6 set on current-sharing bus error
// RL10: Bit 5 when monitor below limit minus 10%
// RL11: Bit 4 when monitor above limit plus 10%
// RL12: Bit 3 on lost external clock sync
// RL13: Bit 1 when monitor below undervoltage limit
// RL14: Bit 0 when monitor above overvoltage limit
// RL15: 88h returns input voltage, Linear-11
// RL16: 89h returns input current, Linear-11
// RL17: 8Bh returns paged output voltage, unsigned 16
// RL18: Word bit 2 mirrors temperature byte
// RL19: Word bit 1 mirrors communication byte
// RL20: Word bit 9 set by any detailed bit
// RL21: Flags stay set until clear or reset
// RL22: Host only reads; writes reported as error
`timescale 1ns/1ps
module pst_status_telemetry_regs #(
    parameter int PAGES = 2,
    parameter int MON_WIDTH = 16
) (
    input wire logic clk_i,
    input wire logic reset_i,
    // Decoded command access
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [$clog2(PAGES)-1:0] page_i,
    input wire logic cmd_supported_i,
    input wire logic bad_data_i,
    input wire logic packet_error_i,
    input wire logic other_comm_fault_i,
    input wire logic clear_faults_i,
    // Event sources
    input wire logic [PAGES-1:0] over_temp_fault_i,
    input wire logic [PAGES-1:0] over_temp_warning_i,
    input wire logic [PAGES-1:0] under_temp_warning_i,
    input wire logic [PAGES-1:0] under_temp_fault_i,
    input wire logic current_sharing_bus_error_i,
    input wire logic sync_lost_i,
    input wire logic [MON_WIDTH-1:0] monitor_pin_i,
    input wire logic [MON_WIDTH-1:0] monitor_undervoltage_limit_i,
    input wire logic [MON_WIDTH-1:0] monitor_overvoltage_limit_i,
    // Telemetry from converters
    input wire logic [15:0] input_voltage_i,
    input wire logic [15:0] input_current_i,
    input wire logic [PAGES*16-1:0] output_voltage_i,
    // Read answer and status word summary bits
    output logic rd_valid_o,
    output logic [15:0] rd_data_o,
    output logic [1:0] rd_bytes_o,
    output logic [PAGES-1:0] word_temp_o,
    output logic word_cml_o,
    output logic [PAGES-1:0] word_other_o
);
    import pst_pkg::*;

    // Per-page temperature bytes and their events
    logic [7:0] temp_set [PAGES]; // Per-page temperature events
    logic [7:0] temp_flags [PAGES]; // Per-page temperature bytes
    // Global status bytes and their events
    logic [7:0] cml_set; // Communication events
    logic [7:0] cml_flags; // Communication byte
    logic [7:0] mon_set; // Monitor events
    logic [7:0] mon_flags; // Monitor byte
    // Window comparator results
    logic uv_f; // Below undervoltage limit
    logic ov_f; // Above overvoltage limit
    logic uv_w; // Below undervoltage band
    logic ov_w; // Above overvoltage band
    logic known_cmd; // Command belongs to this bank
    // Read answer stage
    logic rd_valid_reg; // Answer strobe
    logic rd_valid_next; // Next answer strobe
    logic [15:0] rd_data_reg; // Answer data
    logic [15:0] rd_data_next; // Next answer data
    logic [1:0] rd_bytes_reg; // Answer length
    logic [1:0] rd_bytes_next; // Next answer length
    // Telemetry samples
    logic [15:0] vin_reg; // Input voltage sample
    logic [15:0] vin_next; // Next input voltage
    logic [15:0] iin_reg; // Input current sample
    logic [15:0] iin_next; // Next input current
    logic [PAGES*16-1:0] vout_reg; // Output voltage samples
    logic [PAGES*16-1:0] vout_next; // Next output voltages
    // Status word summary bits
    logic [PAGES-1:0] wtemp_reg; // Word bit 2 per page
    logic [PAGES-1:0] wtemp_next; // Next word bit 2
    logic wcml_reg; // Word bit 1
    logic wcml_next; // Next word bit 1
    logic [PAGES-1:0] wother_reg; // Word bit 9 per page
    logic [PAGES-1:0] wother_next; // Next word bit 9

    // A write to any of these codes is refused and flagged,
    // never stored, since every register here is read only.
    // True for codes this bank answers
    function automatic logic bank_code(input logic [7:0] code);
        bank_code = (code == PST_CMD_TEMP_STATUS) || (code == PST_CMD_CML_STATUS)
                 || (code == PST_CMD_MON_STATUS) || (code == PST_CMD_VIN_READING)
                 || (code == PST_CMD_IIN_READING) || (code == PST_CMD_VOUT_READING);
    endfunction : bank_code

    assign known_cmd = bank_code(cmd_code_i);

    // Compare is combinational; the sticky byte adds the register.
    // A limit change acts on the very next edge.
    // Monitor pin window compare
    pst_monitor_compare #(
        .WIDTH(MON_WIDTH)
    ) u_mon_cmp (
        .level_i(monitor_pin_i),
        .uv_limit_i(monitor_undervoltage_limit_i),
        .ov_limit_i(monitor_overvoltage_limit_i),
        .uv_fault_o(uv_f),
        .ov_fault_o(ov_f),
        .uv_warn_o(uv_w),
        .ov_warn_o(ov_w)
    );

    // Temperature inputs are levels; the sticky byte holds a short
    // event after its source has gone away.
    // Temperature event mapping per page
    always_comb begin
        for (int p = 0; p < PAGES; p++) begin
            temp_set[p] = PST_STATUS_RESET;
            temp_set[p][PST_TEMP_OVER_FAULT_BIT] = over_temp_fault_i[p]; // RL2
            temp_set[p][PST_TEMP_OVER_WARN_BIT] = over_temp_warning_i[p]; // RL2
            temp_set[p][PST_TEMP_UNDER_WARN_BIT] = under_temp_warning_i[p]; // RL2
            temp_set[p][PST_TEMP_UNDER_FAULT_BIT] = under_temp_fault_i[p]; // RL2
        end
    end

    // One byte per page; a clear pulse empties every page at once.
    // The lower nibble is never stored.
    // Paged temperature bytes, unused nibble masked off
    for (genvar g = 0; g < PAGES; g++) begin : g_temp
        pst_sticky_byte #(
            .USED_MASK(PST_TEMP_USED_MASK)
        ) u_temp (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .clear_i(clear_faults_i),
            .set_i(temp_set[g]),
            .flags_o(temp_flags[g]) // RL1
        );
    end

    // Bit 7 leans on the front end's support decode, so codes owned
    // by neighbouring banks are not flagged here. Writes to this
    // bank's own codes land in bit 1 instead.
    // Communication error mapping; a write to any bank code is refused
    always_comb begin
        cml_set = PST_STATUS_RESET;
        cml_set[PST_CML_BAD_CMD_BIT] = cmd_valid_i && !cmd_supported_i; // RL4
        cml_set[PST_CML_BAD_DATA_BIT] = bad_data_i; // RL5
        cml_set[PST_CML_PEC_BIT] = packet_error_i; // RL6
        cml_set[PST_CML_OTHER_BIT] = other_comm_fault_i
            || (cmd_valid_i && cmd_write_i && known_cmd); // RL7 RL22
    end

    // Global byte: one copy serves every page.
    // Bits 4:2 and 0 are masked inside the byte.
    pst_sticky_byte #(
        .USED_MASK(PST_CML_USED_MASK)
    ) u_cml (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .clear_i(clear_faults_i),
        .set_i(cml_set),
        .flags_o(cml_flags) // RL3
    );

    // Warning and fault bits can set together when the pin
    // jumps past both thresholds in one cycle.
    // Monitor and sync event mapping
    always_comb begin
        mon_set = PST_STATUS_RESET;
        mon_set[PST_MON_SHARE_BIT] = current_sharing_bus_error_i; // RL9
        mon_set[PST_MON_UV_WARN_BIT] = uv_w; // RL10
        mon_set[PST_MON_OV_WARN_BIT] = ov_w; // RL11
        mon_set[PST_MON_SYNC_BIT] = sync_lost_i; // RL12
        mon_set[PST_MON_UV_FAULT_BIT] = uv_f; // RL13
        mon_set[PST_MON_OV_FAULT_BIT] = ov_f; // RL14
    end

    // Global byte; bits 7 and 2 are masked inside it.
    // Sync and sharing inputs may be pulses or levels.
    pst_sticky_byte #(
        .USED_MASK(PST_MON_USED_MASK)
    ) u_mon (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .clear_i(clear_faults_i),
        .set_i(mon_set),
        .flags_o(mon_flags) // RL8
    );

    // Readings are resampled every cycle, so a read never sees a
    // half-updated word. Summary bits trail the status bytes by one
    // edge; that lag buys a clean flop output.
    // Telemetry sampling and status word summary
    always_comb begin
        vin_next = input_voltage_i; // RL15
        iin_next = input_current_i; // RL16
        vout_next = output_voltage_i; // RL17
        wcml_next = |cml_flags; // RL19
        for (int p = 0; p < PAGES; p++) begin
            wtemp_next[p] = |temp_flags[p]; // RL18
            wother_next[p] = (|temp_flags[p]) || (|cml_flags) || (|mon_flags); // RL20
        end
    end

    // One answer per read of an own code, registered on the
    // command edge. Byte answers keep the upper byte zero so the
    // front end can send the low byte alone.
    // Read answer; the mux sees sampled telemetry, so a reading is one cycle old
    always_comb begin
        rd_valid_next = 1'b0;
        rd_data_next = PST_READING_RESET;
        rd_bytes_next = 2'd0;
        if (cmd_valid_i && !cmd_write_i && known_cmd) begin
            rd_valid_next = 1'b1;
            rd_bytes_next = 2'd1;
            case (cmd_code_i)
                PST_CMD_TEMP_STATUS: begin
                    rd_data_next = {8'h00, temp_flags[page_i]}; // RL1
                end
                PST_CMD_CML_STATUS: begin
                    rd_data_next = {8'h00, cml_flags}; // RL3
                end
                PST_CMD_MON_STATUS: begin
                    rd_data_next = {8'h00, mon_flags}; // RL8
                end
                PST_CMD_VIN_READING: begin
                    rd_data_next = vin_reg; // RL15
                    rd_bytes_next = 2'd2;
                end
                PST_CMD_IIN_READING: begin
                    rd_data_next = iin_reg; // RL16
                    rd_bytes_next = 2'd2;
                end
                PST_CMD_VOUT_READING: begin
                    rd_data_next = vout_reg[page_i*16 +: 16]; // RL17
                    rd_bytes_next = 2'd2;
                end
                default: begin
                    rd_valid_next = 1'b0;
                    rd_bytes_next = 2'd0;
                end
            endcase
        end
    end

    // Synchronous reset clears the answer stage and the samples,
    // so no stale reading or strobe appears in the first cycle
    // after release.
    // Register stage for answer, telemetry samples and summary bits
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rd_valid_reg <= 1'b0;
            rd_data_reg <= PST_READING_RESET;
            rd_bytes_reg <= 2'd0;
            vin_reg <= PST_READING_RESET;
            iin_reg <= PST_READING_RESET;
            vout_reg <= '0;
            wtemp_reg <= '0;
            wcml_reg <= 1'b0;
            wother_reg <= '0;
        end else begin
            rd_valid_reg <= rd_valid_next;
            rd_data_reg <= rd_data_next;
            rd_bytes_reg <= rd_bytes_next;
            vin_reg <= vin_next;
            iin_reg <= iin_next;
            vout_reg <= vout_next;
            wtemp_reg <= wtemp_next;
            wcml_reg <= wcml_next;
            wother_reg <= wother_next;
        end
    end

    // Outputs come straight from flops, so the front end sees
    // no glitches from the read mux.
    assign rd_valid_o = rd_valid_reg;
    assign rd_data_o = rd_data_reg;
    assign rd_bytes_o = rd_bytes_reg;
    assign word_temp_o = wtemp_reg;
    assign word_cml_o = wcml_reg;
    assign word_other_o = wother_reg;
endmodule : pst_status_telemetry_regs

/* File: tb/pst_status_telemetry_regs_asserts.sv */
// Checker for the status and telemetry bank, bound to its top ports.
// Assumes telemetry inputs are held steady around their reads.
`timescale 1ns/1ps
module pst_status_telemetry_regs_asserts #(
    parameter int PAGES = 2
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic cmd_supported_i,
    input wire logic clear_faults_i,
    input wire logic [PAGES-1:0] over_temp_fault_i,
    input wire logic current_sharing_bus_error_i,
    input wire logic sync_lost_i,
    input wire logic [15:0] input_voltage_i,
    input wire logic rd_valid_o,
    input wire logic [15:0] rd_data_o,
    input wire logic [1:0] rd_bytes_o,
    input wire logic [PAGES-1:0] word_temp_o,
    input wire logic word_cml_o,
    input wire logic [PAGES-1:0] word_other_o
);
    logic rd_req; // Read command this cycle
    logic byte_cmd; // One of the three status bytes
    logic mapped; // Any of the six codes
    assign rd_req = cmd_valid_i & ~cmd_write_i;
    assign byte_cmd = cmd_code_i inside {8'h7d, 8'h7e, 8'h80};
    assign mapped = byte_cmd | (cmd_code_i inside {8'h88, 8'h89, 8'h8b});
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_ans_byte; rd_req && byte_cmd |=> rd_valid_o && rd_bytes_o == 2'h1
        && rd_data_o[15:8] == 8'h00; endproperty
    a_ans_byte: assert property (p_ans_byte) else $error("byte answer");
    property p_ans_word; rd_req && mapped && !byte_cmd
        |=> rd_valid_o && rd_bytes_o == 2'h2; endproperty
    a_ans_word: assert property (p_ans_word) else $error("word answer");
    property p_no_ans; !(rd_req && mapped) |=> !rd_valid_o; endproperty
    a_no_ans: assert property (p_no_ans) else $error("stray answer");
    property p_temp_unused; rd_req && cmd_code_i == 8'h7d |=> rd_data_o[3:0] == 4'h0;
    endproperty
    a_temp_unused: assert property (p_temp_unused) else $error("temp unused");
    property p_cml_unused; rd_req && cmd_code_i == 8'h7e
        |=> rd_data_o[4:2] == 3'h0 && !rd_data_o[0]; endproperty
    a_cml_unused: assert property (p_cml_unused) else $error("comm unused");
    property p_vin; rd_req && cmd_code_i == 8'h88 && $stable(input_voltage_i)
        |=> rd_data_o == $past(input_voltage_i); endproperty
    a_vin: assert property (p_vin) else $error("vin reading");
    property p_bad_cmd; cmd_valid_i && !cmd_supported_i |-> ##2 word_cml_o; endproperty
    a_bad_cmd: assert property (p_bad_cmd) else $error("bad code");
    property p_ro_wr; cmd_valid_i && cmd_write_i && mapped |-> ##2 word_cml_o; endproperty
    a_ro_wr: assert property (p_ro_wr) else $error("ro write");
    // Two-cycle guard: the summary lags a clear pulse by one stage
    property p_sticky; word_cml_o && !clear_faults_i && !$past(clear_faults_i)
        |=> word_cml_o; endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");
    property p_temp_word; over_temp_fault_i[1] |-> ##2 word_temp_o[1] && word_other_o[1];
    endproperty
    a_temp_word: assert property (p_temp_word) else $error("temp summary");
    property p_mon_word; sync_lost_i || current_sharing_bus_error_i
        |-> ##2 &word_other_o; endproperty
    a_mon_word: assert property (p_mon_word) else $error("mon summary");
endmodule : pst_status_telemetry_regs_asserts

/* File: tb/pst_host_model.sv */
// Host model: issues one decoded command per call, then idles a cycle.
// Assumes it is called just after a rising clock edge.
`timescale 1ns/1ps
module pst_host_model #(
    parameter int PAGES = 2
) (
    input wire logic clk_i,
    input wire logic rd_valid_i,
    input wire logic [15:0] rd_data_i,
    input wire logic [1:0] rd_bytes_i,
    output logic cmd_valid_o,
    output logic cmd_write_o,
    output logic [7:0] cmd_code_o,
    output logic [$clog2(PAGES)-1:0] page_o,
    output logic cmd_supported_o
);
    logic got_valid; // Answer seen after the command edge
    logic [15:0] got_data;
    logic [1:0] got_bytes;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_code_o = 8'h00;
        page_o = '0;
        cmd_supported_o = 1'b1;
    end
    // Writes only when a test asks for a refusal
    task automatic issue(input logic w, input logic [7:0] c,
                         input logic [$clog2(PAGES)-1:0] p, input logic s);
        cmd_valid_o = 1'b1;
        cmd_write_o = w;
        cmd_code_o = c;
        page_o = p;
        cmd_supported_o = s;
        @(posedge clk_i);
        #1;
        got_valid = rd_valid_i;
        got_data = rd_data_i;
        got_bytes = rd_bytes_i;
        // Write and code qualifiers turn to junk once released; page and support keep their values
        cmd_valid_o = 1'b0;
        cmd_write_o = ~w;
        cmd_code_o = ~c;
        @(posedge clk_i);
        #1;
    endtask : issue
endmodule : pst_host_model

/* File: tb/pst_status_telemetry_regs_test.sv */
// Testbench for the status and telemetry bank, with host model and checker.
// Assumes inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module pst_status_telemetry_regs_test;
    import pst_pkg::*;
    logic clk_i, reset_i, cmd_valid_i, cmd_write_i, cmd_supported_i, clear_faults_i;
    logic bad_data_i, packet_error_i, other_comm_fault_i, sync_lost_i;
    logic current_sharing_bus_error_i, rd_valid_o, word_cml_o;
    logic [7:0] cmd_code_i;
    logic [0:0] page_i;
    logic [1:0] over_temp_fault_i, over_temp_warning_i, under_temp_warning_i;
    logic [1:0] under_temp_fault_i, rd_bytes_o, word_temp_o, word_other_o;
    logic [15:0] monitor_pin_i, monitor_undervoltage_limit_i, monitor_overvoltage_limit_i;
    logic [15:0] input_voltage_i, input_current_i, rd_data_o;
    logic [31:0] output_voltage_i;
    int n_errors = 0;
    int samples_checked = 0;
    logic [15:0] pins [6] = '{16'h0352, 16'h03b6, 16'h08ca, 16'h0834, 16'h05dc, 16'h05dc};
    logic [15:0] mexp [6] = '{16'h0022, 16'h0002, 16'h0011, 16'h0001, 16'h0008, 16'h0040};
    pst_status_telemetry_regs #(.PAGES(2), .MON_WIDTH(16)) uut (.clk_i(clk_i),
        .reset_i(reset_i), .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i),
        .cmd_code_i(cmd_code_i), .page_i(page_i), .cmd_supported_i(cmd_supported_i),
        .bad_data_i(bad_data_i), .packet_error_i(packet_error_i),
        .other_comm_fault_i(other_comm_fault_i), .clear_faults_i(clear_faults_i),
        .over_temp_fault_i(over_temp_fault_i), .over_temp_warning_i(over_temp_warning_i),
        .under_temp_warning_i(under_temp_warning_i), .under_temp_fault_i(under_temp_fault_i),
        .current_sharing_bus_error_i(current_sharing_bus_error_i), .sync_lost_i(sync_lost_i),
        .monitor_pin_i(monitor_pin_i),
        .monitor_undervoltage_limit_i(monitor_undervoltage_limit_i),
        .monitor_overvoltage_limit_i(monitor_overvoltage_limit_i),
        .input_voltage_i(input_voltage_i), .input_current_i(input_current_i),
        .output_voltage_i(output_voltage_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
        .rd_bytes_o(rd_bytes_o), .word_temp_o(word_temp_o), .word_cml_o(word_cml_o),
        .word_other_o(word_other_o));
    pst_host_model #(.PAGES(2)) host (.clk_i(clk_i), .rd_valid_i(rd_valid_o),
        .rd_data_i(rd_data_o), .rd_bytes_i(rd_bytes_o), .cmd_valid_o(cmd_valid_i),
        .cmd_write_o(cmd_write_i), .cmd_code_o(cmd_code_i), .page_o(page_i),
        .cmd_supported_o(cmd_supported_i));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic step();
        @(posedge clk_i);
        #1;
    endtask : step
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Read and check answer, data and length
    task automatic rd(input logic [7:0] c, input logic p, input logic [15:0] e,
                      input logic [1:0] b);
        host.issue(1'b0, c, p, 1'b1);
        chk({15'h0, host.got_valid}, 16'h0001);
        chk(host.got_data, e);
        chk({14'h0, host.got_bytes}, {14'h0, b});
    endtask : rd
    task automatic clear();
        clear_faults_i = 1'b1;
        step();
        clear_faults_i = 1'b0;
    endtask : clear
    task automatic tally_and_finish();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    // Hang guard
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        {clear_faults_i, bad_data_i, packet_error_i, other_comm_fault_i} = 4'h0;
        {sync_lost_i, current_sharing_bus_error_i} = 2'h0;
        {over_temp_fault_i, over_temp_warning_i} = 4'h0;
        {under_temp_warning_i, under_temp_fault_i} = 4'h0;
        monitor_undervoltage_limit_i = 16'h03e8;
        monitor_overvoltage_limit_i = 16'h07d0;
        monitor_pin_i = 16'h05dc;
        input_voltage_i = 16'hd3a5;
        input_current_i = 16'h0bcd;
        output_voltage_i = 32'h2a00_1999;
        reset_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        rd(8'h7d, 1'b0, 16'h0000, 2'h1);
        rd(8'h7e, 1'b0, 16'h0000, 2'h1);
        rd(8'h80, 1'b0, 16'h0000, 2'h1);
        rd(8'h88, 1'b0, 16'hd3a5, 2'h2);
        rd(8'h89, 1'b0, 16'h0bcd, 2'h2);
        rd(8'h8b, 1'b0, 16'h1999, 2'h2);
        rd(8'h8b, 1'b1, 16'h2a00, 2'h2);
        // Short temperature events, read after they are gone
        over_temp_fault_i = 2'b10;
        under_temp_warning_i = 2'b10;
        step();
        {over_temp_fault_i, under_temp_warning_i} = 4'h0;
        step();
        rd(8'h7d, 1'b1, 16'h00a0, 2'h1);
        chk({12'h0, word_temp_o, word_other_o}, 16'h000a);
        rd(8'h7d, 1'b0, 16'h0000, 2'h1);
        over_temp_warning_i = 2'b01;
        under_temp_fault_i = 2'b01;
        step();
        {over_temp_warning_i, under_temp_fault_i} = 4'h0;
        rd(8'h7d, 1'b0, 16'h0050, 2'h1);
        // Refused write and unknown code, then bus errors
        host.issue(1'b1, 8'h7d, 1'b0, 1'b1);
        chk({15'h0, host.got_valid}, 16'h0000);
        host.issue(1'b0, 8'h55, 1'b0, 1'b0);
        chk({15'h0, host.got_valid}, 16'h0000);
        bad_data_i = 1'b1;
        step();
        bad_data_i = 1'b0;
        packet_error_i = 1'b1;
        step();
        packet_error_i = 1'b0;
        rd(8'h7e, 1'b0, 16'h00e2, 2'h1);
        chk({15'h0, word_cml_o}, 16'h0001);
        clear();
        rd(8'h7e, 1'b0, 16'h0000, 2'h1);
        rd(8'h7d, 1'b1, 16'h0000, 2'h1);
        chk({13'h0, word_temp_o, word_cml_o}, 16'h0000);
        other_comm_fault_i = 1'b1;
        step();
        other_comm_fault_i = 1'b0;
        rd(8'h7e, 1'b0, 16'h0002, 2'h1);
        clear();
        // Monitor window, sync loss and sharing bus, one case per row
        for (int i = 0; i < 6; i++) begin
            monitor_pin_i = pins[i];
            sync_lost_i = (i == 4);
            current_sharing_bus_error_i = (i == 5);
            step();
            step();
            monitor_pin_i = 16'h05dc;
            {sync_lost_i, current_sharing_bus_error_i} = 2'h0;
            rd(8'h80, 1'b0, mexp[i], 2'h1);
            clear();
        end
        tally_and_finish();
    end
endmodule : pst_status_telemetry_regs_test
bind pst_status_telemetry_regs pst_status_telemetry_regs_asserts #(.PAGES(PAGES)) u_chk (
    .clk_i(clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i),
    .cmd_code_i(cmd_code_i), .cmd_supported_i(cmd_supported_i),
    .clear_faults_i(clear_faults_i), .over_temp_fault_i(over_temp_fault_i),
    .current_sharing_bus_error_i(current_sharing_bus_error_i), .sync_lost_i(sync_lost_i),
    .input_voltage_i(input_voltage_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .rd_bytes_o(rd_bytes_o), .word_temp_o(word_temp_o), .word_cml_o(word_cml_o),
    .word_other_o(word_other_o));
